// ---- inc/pscc_params.svh ----
`ifndef PSCC_PARAMS_SVH
`define PSCC_PARAMS_SVH

// register byte offsets, one aligned 32-bit word each
`define PSCC_OFF_CTRL 8'h00
`define PSCC_OFF_PERIOD 8'h04
`define PSCC_OFF_WIDTH 8'h08
`define PSCC_OFF_RISE 8'h0C
`define PSCC_OFF_FALL 8'h10
`define PSCC_OFF_DELAY 8'h14
`define PSCC_OFF_DDELAY 8'h18
`define PSCC_OFF_DUTY 8'h1C
`define PSCC_OFF_STATUS 8'h20
`define PSCC_OFF_CODE 8'h24
`define PSCC_OFF_CONFLICT 8'h28
`define PSCC_OFF_IRQ_STAT 8'h2C
`define PSCC_OFF_IRQ_MASK 8'h30

// control field layout
`define PSCC_CTRL_MODE_LSB 0
`define PSCC_CTRL_MODE_MSB 2
`define PSCC_CTRL_RUN_LSB 4
`define PSCC_CTRL_RUN_MSB 5
`define PSCC_CTRL_MASK 32'h0000_0037

// status field layout
`define PSCC_STAT_FLAG_BIT 0
`define PSCC_STAT_PEND_BIT 1

// reset values, time settings in units of PSCC_UNIT_PS picoseconds, duty in hundredths of the period
`define PSCC_RST_CTRL 32'h0000_0000
`define PSCC_RST_PERIOD 32'h0000_03E8
`define PSCC_RST_WIDTH 32'h0000_01F4
`define PSCC_RST_RISE 32'h0000_000A
`define PSCC_RST_FALL 32'h0000_000A
`define PSCC_RST_DELAY 32'h0000_0000
`define PSCC_RST_DDELAY 32'h0000_0000
`define PSCC_RST_DUTY 32'h0000_0032
`define PSCC_RST_MASK 8'h00

// setting resolution and the fixed guard time
`define PSCC_UNIT_PS 100
`define PSCC_GUARD_NS 4
`define PSCC_GUARD_CNT ((`PSCC_GUARD_NS * 1000) / `PSCC_UNIT_PS)

// transition range upper bounds and width range floor
`define PSCC_TRANS_R0_MAX 32'h0000_0064
`define PSCC_TRANS_R1_MAX 32'h0000_03E8
`define PSCC_WIDTH_MIN 32'h0000_0064
`define PSCC_DUTY_FULL 32'h0000_0064

// conflict codes: bit i of the conflict vector reports code -(BASE + i)
`define PSCC_CODE_BASE 32'h0000_01F4
`define PSCC_NUM_CONF 8

`endif

// ---- inc/pscc_pkg.sv ----
`default_nettype none
package pscc_pkg;
	// pulse mode as held in the control register
	typedef enum logic [2:0] {
		pm_single,
		pm_double,
		pm_delayed,
		pm_half_duty,
		pm_ext_width
	} pscc_pulse_mode_type;

	// run mode as held in the control register
	typedef enum logic [1:0] {
		rm_continuous,
		rm_triggered,
		rm_gated,
		rm_burst
	} pscc_run_mode_type;
endpackage
`default_nettype wire

// ---- src/pscc_eval.sv ----
`include "pscc_params.svh"
`default_nettype none
module pscc_eval (
	input wire pscc_pkg::pscc_pulse_mode_type pulse_mode,
	input wire pscc_pkg::pscc_run_mode_type run_mode,
	input wire logic [31:0] pulse_period,
	input wire logic [31:0] pulse_width,
	input wire logic [31:0] rise_transition,
	input wire logic [31:0] fall_transition,
	input wire logic [31:0] single_pulse_delay,
	input wire logic [31:0] double_pulse_delay,
	input wire logic [31:0] duty_cycle,
	output logic [7:0] conflicts
);
	// times eight, so that 0.625 becomes the exact integer factor five
	function automatic logic [39:0] x8(input logic [31:0] v);
		x8 = {5'h00, v, 3'h0};
	endfunction

	// five times the transition sum, the scaled form of 0.625 * (rise + fall)
	function automatic logic [39:0] edge5(input logic [31:0] l, input logic [31:0] t);
		logic [39:0] s;
		s = {8'h00, l} + {8'h00, t};
		edge5 = (s << 2) + s;
	endfunction

	// which transition range a value falls in
	function automatic logic [1:0] trange(input logic [31:0] v);
		if (v <= `PSCC_TRANS_R0_MAX) begin
			trange = 2'h0;
		end else if (v <= `PSCC_TRANS_R1_MAX) begin
			trange = 2'h1;
		end else begin
			trange = 2'h2;
		end
	endfunction

	logic [39:0] e5;
	logic [39:0] w8;
	logic [39:0] g8;
	logic [39:0] we;
	logic [39:0] duty_prod;
	logic [39:0] duty_min;
	logic ext, single, dbl, dly, half, cont;

	// width, delay and period comparisons in eighths of a unit; no division, no rounding loss
	assign e5 = edge5(rise_transition, fall_transition);
	assign w8 = x8(pulse_width);
	assign g8 = x8(32'(`PSCC_GUARD_CNT));
	assign we = w8 + e5;
	assign duty_prod = {32'h0000_0000, duty_cycle[7:0]} * {8'h00, pulse_period};
	assign duty_min = {8'h00, `PSCC_WIDTH_MIN} * {8'h00, `PSCC_DUTY_FULL};

	assign ext = (pulse_mode == pscc_pkg::pm_ext_width);
	assign single = (pulse_mode == pscc_pkg::pm_single);
	assign dbl = (pulse_mode == pscc_pkg::pm_double);
	assign dly = (pulse_mode == pscc_pkg::pm_delayed);
	assign half = (pulse_mode == pscc_pkg::pm_half_duty);
	assign cont = (run_mode == pscc_pkg::rm_continuous);

	// one bit per conflict code, lowest bit is code -500
	assign conflicts[0] = !ext && (e5 >= w8); // [R8]
	assign conflicts[1] = single && cont && (we >= x8(pulse_period)); // [R1]
	assign conflicts[2] = !ext && (trange(rise_transition) != trange(fall_transition)); // [R2]
	assign conflicts[3] = dbl && (we >= x8(double_pulse_delay)); // [R3]
	assign conflicts[4] = dbl && cont && (x8(double_pulse_delay) + we + g8 >= x8(pulse_period)); // [R4]
	assign conflicts[5] = dly && cont && (x8(single_pulse_delay) + we + g8 >= x8(pulse_period)); // [R5]
	assign conflicts[6] = half && (duty_prod < duty_min); // [R6]
	assign conflicts[7] = dly && (we >= x8(single_pulse_delay)); // [R7]
endmodule
`default_nettype wire

// ---- src/pscc_prio.sv ----
`include "pscc_params.svh"
`default_nettype none
module pscc_prio (
	input wire logic [7:0] conflicts,
	output logic any_conflict,
	output logic [31:0] code
);
	logic [31:0] idx;

	// lowest bit (code nearest zero, -500 first) wins when several conflicts stand at once
	always_comb begin
		idx = 32'h0000_0000;
		for (int i = `PSCC_NUM_CONF - 1; i >= 0; i--) begin
			if (conflicts[i]) begin
				idx = 32'(i);
			end
		end
	end

	assign any_conflict = |conflicts;
	// reported as a negative number, zero when clean
	assign code = any_conflict ? (32'h0000_0000 - (`PSCC_CODE_BASE + idx)) : 32'h0000_0000;
endmodule
`default_nettype wire

// ---- src/pscc_top.sv ----
// Functional notes
// R1: single mode, continuous run: width plus 0.625 transitions reaching period gives -501.
// R2: except external width: rise and fall in different ranges gives -502.
// R3: double mode: width plus 0.625 transitions reaching double delay gives -503.
// R4: double, continuous: double delay, width, 0.625 transitions, 4 ns reaching period gives -504.
// R5: delayed, continuous: delay, width, 0.625 transitions, 4 ns reaching period gives -505.
// R6: half duty mode: duty below minimum width range gives -506.
// R7: delayed mode: width plus 0.625 transitions reaching delay gives -507.
// R8: except external width: 0.625 transitions reaching width gives -500.
// R9: re-check after every setting write; flag and code stand until settings are corrected.
`include "pscc_params.svh"
`default_nettype none
module pscc_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic conflict_flag,
	output logic [31:0] conflict_code,
	output logic settings_valid,
	output logic [2:0] core_pulse_mode,
	output logic [1:0] core_run_mode,
	output logic [31:0] core_pulse_period,
	output logic [31:0] core_pulse_width,
	output logic [31:0] core_rise_transition,
	output logic [31:0] core_fall_transition,
	output logic [31:0] core_single_pulse_delay,
	output logic [31:0] core_double_pulse_delay,
	output logic [31:0] core_duty_cycle
);
	// byte lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	logic wait_r;
	logic [31:0] rdata_r;
	logic [31:0] rd_nxt;
	logic wr_commit;
	logic [31:0] ctrl_r;
	logic [31:0] period_r;
	logic [31:0] width_r;
	logic [31:0] rise_r;
	logic [31:0] fall_r;
	logic [31:0] delay_r;
	logic [31:0] ddelay_r;
	logic [31:0] duty_r;
	logic setting_wr;
	logic pend_r;
	logic [7:0] conf_now;
	logic conf_any;
	logic [31:0] code_now;
	logic [7:0] conf_r;
	logic flag_r;
	logic [31:0] code_r;
	logic [7:0] stat_r;
	logic [7:0] stat_nxt;
	logic [7:0] stat_clr;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic irq_r;
	logic valid_r;
	logic [2:0] cmode_r;
	logic [1:0] crun_r;
	logic [31:0] cper_r;
	logic [31:0] cwid_r;
	logic [31:0] crise_r;
	logic [31:0] cfall_r;
	logic [31:0] cdel_r;
	logic [31:0] cddel_r;
	logic [31:0] cduty_r;

	// a write lands only at the edge where the master sees waitrequest low
	assign wr_commit = avs_write && !wait_r;

	// waitrequest drops for one cycle after a request is seen; fixed two-edge answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wait_r <= 1'b1;
		end else if (wait_r && (avs_read || avs_write)) begin
			wait_r <= 1'b0;
		end else begin
			wait_r <= 1'b1;
		end
	end

	// read mux; unmapped offsets read as zero
	always_comb begin
		rd_nxt = 32'h0000_0000;
		case (avs_address)
			`PSCC_OFF_CTRL: rd_nxt = ctrl_r;
			`PSCC_OFF_PERIOD: rd_nxt = period_r;
			`PSCC_OFF_WIDTH: rd_nxt = width_r;
			`PSCC_OFF_RISE: rd_nxt = rise_r;
			`PSCC_OFF_FALL: rd_nxt = fall_r;
			`PSCC_OFF_DELAY: rd_nxt = delay_r;
			`PSCC_OFF_DDELAY: rd_nxt = ddelay_r;
			`PSCC_OFF_DUTY: rd_nxt = duty_r;
			`PSCC_OFF_STATUS: begin
				rd_nxt[`PSCC_STAT_FLAG_BIT] = flag_r;
				rd_nxt[`PSCC_STAT_PEND_BIT] = pend_r;
			end
			`PSCC_OFF_CODE: rd_nxt = code_r;
			`PSCC_OFF_CONFLICT: rd_nxt = {24'h00_0000, conf_r};
			`PSCC_OFF_IRQ_STAT: rd_nxt = {24'h00_0000, stat_r};
			`PSCC_OFF_IRQ_MASK: rd_nxt = {24'h00_0000, mask_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data is caught at the edge that drops waitrequest and held through the answer
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rdata_r <= 32'h0000_0000;
		end else if (wait_r && avs_read) begin
			rdata_r <= rd_nxt;
		end
	end

	// pulse and run mode; unused control bits are forced to zero
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl_r <= `PSCC_RST_CTRL;
		end else if (wr_commit && avs_address == `PSCC_OFF_CTRL) begin
			ctrl_r <= merge(ctrl_r, avs_writedata, avs_byteenable) & `PSCC_CTRL_MASK;
		end
	end

	// period setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			period_r <= `PSCC_RST_PERIOD;
		end else if (wr_commit && avs_address == `PSCC_OFF_PERIOD) begin
			period_r <= merge(period_r, avs_writedata, avs_byteenable);
		end
	end

	// width setting; stored even when it conflicts, so software reads back what it wrote
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			width_r <= `PSCC_RST_WIDTH;
		end else if (wr_commit && avs_address == `PSCC_OFF_WIDTH) begin
			width_r <= merge(width_r, avs_writedata, avs_byteenable);
		end
	end

	// rise transition setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rise_r <= `PSCC_RST_RISE;
		end else if (wr_commit && avs_address == `PSCC_OFF_RISE) begin
			rise_r <= merge(rise_r, avs_writedata, avs_byteenable);
		end
	end

	// fall transition setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			fall_r <= `PSCC_RST_FALL;
		end else if (wr_commit && avs_address == `PSCC_OFF_FALL) begin
			fall_r <= merge(fall_r, avs_writedata, avs_byteenable);
		end
	end

	// single pulse delay setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			delay_r <= `PSCC_RST_DELAY;
		end else if (wr_commit && avs_address == `PSCC_OFF_DELAY) begin
			delay_r <= merge(delay_r, avs_writedata, avs_byteenable);
		end
	end

	// double pulse delay setting
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ddelay_r <= `PSCC_RST_DDELAY;
		end else if (wr_commit && avs_address == `PSCC_OFF_DDELAY) begin
			ddelay_r <= merge(ddelay_r, avs_writedata, avs_byteenable);
		end
	end

	// duty cycle setting; only the low byte is ever used by the check
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			duty_r <= `PSCC_RST_DUTY;
		end else if (wr_commit && avs_address == `PSCC_OFF_DUTY) begin
			duty_r <= merge(duty_r, avs_writedata, avs_byteenable);
		end
	end

	// any write to the control or setting words asks for a fresh check
	assign setting_wr = wr_commit && (avs_address <= `PSCC_OFF_DUTY) && (avs_address[1:0] == 2'h0);

	// pending starts set so the reset values are checked once as well
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pend_r <= 1'b1;
		end else begin
			pend_r <= setting_wr; // [R9]
		end
	end

	pscc_eval u_eval (
		.pulse_mode(pscc_pkg::pscc_pulse_mode_type'(ctrl_r[`PSCC_CTRL_MODE_MSB:`PSCC_CTRL_MODE_LSB])),
		.run_mode(pscc_pkg::pscc_run_mode_type'(ctrl_r[`PSCC_CTRL_RUN_MSB:`PSCC_CTRL_RUN_LSB])),
		.pulse_period(period_r),
		.pulse_width(width_r),
		.rise_transition(rise_r),
		.fall_transition(fall_r),
		.single_pulse_delay(delay_r),
		.double_pulse_delay(ddelay_r),
		.duty_cycle(duty_r),
		.conflicts(conf_now)
	);

	pscc_prio u_prio (
		.conflicts(conf_now),
		.any_conflict(conf_any),
		.code(code_now)
	);

	// conflict vector is latched once per check and held until the next setting write
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			conf_r <= 8'h00;
		end else if (pend_r) begin
			conf_r <= conf_now; // [R1] [R2] [R3] [R4] [R5] [R6] [R7] [R8]
		end
	end

	// flag and code move on the same edge, so software never sees one without the other
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			flag_r <= 1'b0;
			code_r <= 32'h0000_0000;
		end else if (pend_r) begin
			flag_r <= conf_any; // [R9]
			code_r <= code_now; // [R9]
		end
	end

	// the core only ever sees a clean set; a bad write leaves the last good set running
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmode_r <= 3'h0;
			crun_r <= 2'h0;
			cper_r <= `PSCC_RST_PERIOD;
			cwid_r <= `PSCC_RST_WIDTH;
			crise_r <= `PSCC_RST_RISE;
			cfall_r <= `PSCC_RST_FALL;
			cdel_r <= `PSCC_RST_DELAY;
			cddel_r <= `PSCC_RST_DDELAY;
			cduty_r <= `PSCC_RST_DUTY;
		end else if (pend_r && !conf_any) begin
			cmode_r <= ctrl_r[`PSCC_CTRL_MODE_MSB:`PSCC_CTRL_MODE_LSB];
			crun_r <= ctrl_r[`PSCC_CTRL_RUN_MSB:`PSCC_CTRL_RUN_LSB];
			cper_r <= period_r;
			cwid_r <= width_r;
			crise_r <= rise_r;
			cfall_r <= fall_r;
			cdel_r <= delay_r;
			cddel_r <= ddelay_r;
			cduty_r <= duty_r;
		end
	end

	// one-cycle strobe each time a clean set is handed to the core
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= pend_r && !conf_any;
		end
	end

	// sticky conflict events, cleared by writing ones; a new event beats a clear
	always_comb begin
		stat_clr = 8'h00;
		if (wr_commit && avs_address == `PSCC_OFF_IRQ_STAT) begin
			stat_clr = 8'(merge(32'h0000_0000, avs_writedata, avs_byteenable));
		end
		stat_nxt = (stat_r & ~stat_clr) | (pend_r ? conf_now : 8'h00);
	end

	// mask uses the status layout
	always_comb begin
		mask_nxt = mask_r;
		if (wr_commit && avs_address == `PSCC_OFF_IRQ_MASK) begin
			mask_nxt = 8'(merge({24'h00_0000, mask_r}, avs_writedata, avs_byteenable));
		end
	end

	// sticky event status
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stat_r <= 8'h00;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// interrupt mask
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_r <= `PSCC_RST_MASK;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// irq built from next values so it tracks status and mask on the same edge
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_nxt & mask_nxt);
		end
	end

	assign avs_readdata = rdata_r;
	assign avs_waitrequest = wait_r;
	assign irq = irq_r;
	assign conflict_flag = flag_r;
	assign conflict_code = code_r;
	assign settings_valid = valid_r;
	assign core_pulse_mode = cmode_r;
	assign core_run_mode = crun_r;
	assign core_pulse_period = cper_r;
	assign core_pulse_width = cwid_r;
	assign core_rise_transition = crise_r;
	assign core_fall_transition = cfall_r;
	assign core_single_pulse_delay = cdel_r;
	assign core_double_pulse_delay = cddel_r;
	assign core_duty_cycle = cduty_r;
endmodule
`default_nettype wire

// ---- dv/pscc_top_asserts.sv ----
`default_nettype none
module pscc_top_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic conflict_flag,
	input wire logic [31:0] conflict_code,
	input wire logic settings_valid
);
	// a setting write lands at the edge where waitrequest is sampled low
	logic set_wr_done;
	assign set_wr_done = avs_write && !avs_waitrequest && (avs_address <= 8'h1C);

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	AST_WAIT_SHORT: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	AST_CODE_RANGE: assert property (conflict_flag |-> conflict_code inside {[32'hFFFF_FE05:32'hFFFF_FE0C]})
		else $error("flagged code outside -507..-500");
	AST_CLEAN_ZERO: assert property (!conflict_flag |-> conflict_code == 32'h0000_0000)
		else $error("code not zero while clean");
	AST_VALID_CLEAN: assert property (settings_valid |-> !conflict_flag)
		else $error("settings handed on while in conflict");
	AST_VALID_PULSE: assert property (settings_valid |=> !settings_valid)
		else $error("settings valid longer than one cycle");
	// the outcome may only move two edges after a setting write; it stands otherwise
	AST_CODE_HOLD: assert property ($changed(conflict_code) |-> $past(set_wr_done, 2))
		else $error("code changed without a setting write");
	AST_FLAG_CODE: assert property ($changed(conflict_flag) |-> $changed(conflict_code))
		else $error("flag moved without the code");
	AST_RDATA_HOLD: assert property ($changed(avs_readdata) |-> $past(avs_read))
		else $error("read data changed without a read");
endmodule

bind pscc_top pscc_top_asserts i_asserts (
	.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.conflict_flag(conflict_flag), .conflict_code(conflict_code), .settings_valid(settings_valid)
);
`default_nettype wire

// ---- dv/pscc_host.sv ----
`default_nettype none
module pscc_host (
	input wire logic clock,
	input wire logic avs_waitrequest,
	input wire logic [31:0] avs_readdata,
	output logic [7:0] avs_address,
	output logic avs_read,
	output logic avs_write,
	output logic [31:0] avs_writedata,
	output logic hang
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle bus at time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		hang = 1'b0;
	end

	// request held until waitrequest is sampled low; a bus that never answers raises hang
	task automatic xfer(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= rd;
		avs_write <= !rd;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest && n < 64);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest) hang <= 1'b1;
	endtask
endmodule
`default_nettype wire

// ---- dv/pscc_top_test.sv ----
`include "pscc_params.svh"
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; $display("ERROR %0t got %0h exp %0h", $time, (a), (e)); end end
module pscc_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest, irq, conflict_flag, settings_valid, hang;
	logic [31:0] avs_writedata, avs_readdata, conflict_code, q, want;
	logic [1:0] core_run_mode;
	// core outputs indexed like the setting columns of the case table
	logic [31:0] core [1:7];
	int valid_count = 0;
	int v0;
	logic [2:0] core_pulse_mode;
	int miscompares = 0;
	int check_count = 0;
	// ctrl, period, width, rise, fall, delay, ddelay, duty, expected code magnitude (0 clean)
	logic [11:0] tv [17][9] = '{
		'{12'h010, 12'h3E8, 12'h1F4, 12'h190, 12'h190, 12'h000, 12'h000, 12'h032, 12'h1F4},
		'{12'h010, 12'h3E8, 12'h1F4, 12'h190, 12'h18F, 12'h000, 12'h000, 12'h032, 12'h000},
		'{12'h000, 12'h3E8, 12'h3DE, 12'h008, 12'h008, 12'h000, 12'h000, 12'h032, 12'h1F5},
		'{12'h000, 12'h3E8, 12'h3DD, 12'h008, 12'h008, 12'h000, 12'h000, 12'h032, 12'h000},
		'{12'h000, 12'h3E8, 12'h1F4, 12'h190, 12'h190, 12'h000, 12'h000, 12'h032, 12'h1F4},
		'{12'h010, 12'h3E8, 12'h1F4, 12'h064, 12'h065, 12'h000, 12'h000, 12'h032, 12'h1F6},
		'{12'h024, 12'h3E8, 12'h064, 12'h064, 12'h3E9, 12'h000, 12'h000, 12'h032, 12'h000},
		'{12'h011, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h1FE, 12'h032, 12'h1F7},
		'{12'h031, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h1FF, 12'h032, 12'h000},
		'{12'h001, 12'h47E, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h258, 12'h032, 12'h1F8},
		'{12'h001, 12'h47F, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h258, 12'h032, 12'h000},
		'{12'h002, 12'h47E, 12'h1F4, 12'h008, 12'h008, 12'h258, 12'h000, 12'h032, 12'h1F9},
		'{12'h002, 12'h47F, 12'h1F4, 12'h008, 12'h008, 12'h258, 12'h000, 12'h032, 12'h000},
		'{12'h013, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h000, 12'h009, 12'h1FA},
		'{12'h033, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h000, 12'h000, 12'h00A, 12'h000},
		'{12'h012, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h1FE, 12'h000, 12'h032, 12'h1FB},
		'{12'h022, 12'h3E8, 12'h1F4, 12'h008, 12'h008, 12'h1FF, 12'h000, 12'h032, 12'h000}
	};

	always #5 clock = ~clock;

	pscc_top i_dut (
		.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.conflict_flag(conflict_flag), .conflict_code(conflict_code), .settings_valid(settings_valid),
		.core_pulse_mode(core_pulse_mode), .core_run_mode(core_run_mode), .core_pulse_period(core[1]),
		.core_pulse_width(core[2]), .core_rise_transition(core[3]), .core_fall_transition(core[4]),
		.core_single_pulse_delay(core[5]), .core_double_pulse_delay(core[6]), .core_duty_cycle(core[7])
	);

	pscc_host i_host (
		.clock(clock), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .hang(hang)
	);

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		i_host.xfer(1'b0, a, d, dummy);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		i_host.xfer(1'b1, a, 32'h0000_0000, d);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// a stuck bus ends the run rather than hanging it
	always @(posedge hang) begin
		miscompares++;
		close_out();
	end

	// counts hand-overs of a clean set to the core
	always @(posedge clock) begin
		if (settings_valid === 1'b1) valid_count++;
	end

	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		rd(`PSCC_OFF_PERIOD, q); `CHK(q, `PSCC_RST_PERIOD)
		rd(`PSCC_OFF_DUTY, q); `CHK(q, `PSCC_RST_DUTY)
		rd(`PSCC_OFF_CODE, q); `CHK(q, 32'h0000_0000)
		// every setting rewritten per case; the last write's check decides the outcome
		for (int i = 0; i < 17; i++) begin
			for (int k = 0; k < 8; k++) wr(8'(k * 4), {20'h00000, tv[i][k]});
			want = (tv[i][8] == 12'h000) ? 32'h0000_0000 : 32'h0000_0000 - {20'h00000, tv[i][8]};
			rd(`PSCC_OFF_CODE, q);
			`CHK(q, want)
			`CHK(conflict_code, want)
			`CHK(conflict_flag, (tv[i][8] != 12'h000))
			if (i == 4) begin
				rd(`PSCC_OFF_CONFLICT, q); `CHK(q, 32'h0000_0003)
			end
			if (tv[i][8] == 12'h000) begin
				for (int k = 1; k < 8; k++) `CHK(core[k], {20'h00000, tv[i][k]})
				`CHK(core_pulse_mode, tv[i][0][2:0])
				`CHK(core_run_mode, tv[i][0][5:4])
			end
		end
		// interrupt: clear, unmask, raise, mask, unmask, clear after correction
		wr(`PSCC_OFF_IRQ_STAT, 32'h0000_00FF);
		rd(`PSCC_OFF_IRQ_STAT, q); `CHK(q, 32'h0000_0000)
		wr(`PSCC_OFF_IRQ_MASK, 32'h0000_0001);
		v0 = valid_count;
		wr(`PSCC_OFF_WIDTH, 32'h0000_0008);
		rd(`PSCC_OFF_IRQ_STAT, q); `CHK(q, 32'h0000_0001)
		`CHK(irq, 1'b1)
		rd(`PSCC_OFF_STATUS, q); `CHK(q, 32'h0000_0001)
		rd(`PSCC_OFF_CONFLICT, q); `CHK(q, 32'h0000_0001)
		`CHK(core[2], 32'h0000_01F4)
		`CHK(valid_count, v0)
		wr(`PSCC_OFF_IRQ_MASK, 32'h0000_0000);
		rd(`PSCC_OFF_CODE, q); `CHK(q, 32'hFFFF_FE0C)
		`CHK(irq, 1'b0)
		wr(`PSCC_OFF_IRQ_MASK, 32'h0000_0001);
		rd(`PSCC_OFF_IRQ_MASK, q); `CHK(q, 32'h0000_0001)
		`CHK(irq, 1'b1)
		wr(`PSCC_OFF_WIDTH, 32'h0000_01F4);
		wr(`PSCC_OFF_IRQ_STAT, 32'h0000_0001);
		rd(`PSCC_OFF_IRQ_STAT, q); `CHK(q, 32'h0000_0000)
		`CHK(irq, 1'b0)
		`CHK(conflict_code, 32'h0000_0000)
		`CHK(valid_count, v0 + 1)
		// read-only and unmapped places
		wr(`PSCC_OFF_CODE, 32'hFFFF_FFFF);
		rd(`PSCC_OFF_CODE, q); `CHK(q, 32'h0000_0000)
		rd(8'h40, q); `CHK(q, 32'h0000_0000)
		// reset in mid-run: a standing conflict and the running set fall back to reset values
		wr(`PSCC_OFF_WIDTH, 32'h0000_0008);
		rd(`PSCC_OFF_CODE, q); `CHK(q, 32'hFFFF_FE0C)
		rst_n <= 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		rd(`PSCC_OFF_WIDTH, q); `CHK(q, `PSCC_RST_WIDTH)
		`CHK(conflict_flag, 1'b0)
		`CHK(core[5], `PSCC_RST_DELAY)
		`CHK(irq, 1'b0)
		close_out();
	end
endmodule
`default_nettype wire
